// >>> core/otf_defines.svh
`ifndef OTF_DEFINES_SVH
`define OTF_DEFINES_SVH

// Register byte offsets
`define OTF_ADDR_FAST_MODE      8'h00
`define OTF_ADDR_FAST_SEL       8'h04
`define OTF_ADDR_RELAY1_SEL     8'h08
`define OTF_ADDR_RELAY2_SEL     8'h0C
`define OTF_ADDR_OC_SEL         8'h10
`define OTF_ADDR_STATUS         8'h14

// Reset values
`define OTF_RST_FAST_MODE       1'b0
`define OTF_RST_FAST_SEL        8'h00
`define OTF_RST_RELAY1_SEL      8'h02
`define OTF_RST_RELAY2_SEL      8'h00
`define OTF_RST_OC_SEL          8'h01

// Field positions and limits
`define OTF_MODE_SWITCH_BIT     0
`define OTF_SEL_MAX             8'h28
`define OTF_CODE_LAST           8'h17

// Status register bits
`define OTF_ST_FAST_BIT         0
`define OTF_ST_RELAY1_BIT       1
`define OTF_ST_RELAY2_BIT       2
`define OTF_ST_OC_BIT           3
`define OTF_ST_SEQ_BIT          4

// Timing
`define OTF_CLK_MHZ             250
`define OTF_SEQ_PULSE_MS        250
`define OTF_SEQ_PULSE_CYCLES    (`OTF_SEQ_PULSE_MS * 1000 * `OTF_CLK_MHZ)
`define OTF_DRV_PREWARN_MS      16'h2710

`endif

// >>> core/otf_pkg.sv
package otf_pkg;

   typedef logic [7:0]  otf_sel_t;
   typedef logic [15:0] otf_val_t;
   typedef logic [23:0] otf_cond_t;

   typedef enum logic [4:0] {
      OTF_C_NONE,
      OTF_C_FREQ_REACHED,
      OTF_C_FREQ_LEVEL_ONE,
      OTF_C_FAULT_STOP,
      OTF_C_MOTOR_OVL_WARN,
      OTF_C_DRIVE_OVL_WARN,
      OTF_C_ZERO_RUN,
      OTF_C_ZERO_ANY,
      OTF_C_UPPER_LIMIT,
      OTF_C_LOWER_LIMIT,
      OTF_C_SET_COUNT,
      OTF_C_DESIG_COUNT,
      OTF_C_LENGTH,
      OTF_C_SEQ_CYCLE,
      OTF_C_RUN_TIME,
      OTF_C_FREQ_LIMITED,
      OTF_C_TORQUE_LIMITED,
      OTF_C_READY,
      OTF_C_RUNNING,
      OTF_C_ANALOG_CMP,
      OTF_C_UNDERVOLTAGE
   } otf_code_t;

endpackage

// >>> core/otf_output_select.sv
// Functional notes
// [RULE1] Fast terminal mode 0 gives pulse output, 1 gives switch output.
// [RULE2] Four terminals each select a condition by code; fast switch accepts 0..40.
// [RULE3] Reset selections: relay one 2, relay two 0, fast switch 0, open collector 1.
// [RULE4] Code 0 never drives its terminal active.
// [RULE5] Code 3 active when the drive stopped on a fault.
// [RULE6] Code 4 active when motor load exceeds the pre-warning threshold.
// [RULE7] Code 5 active from 10 s before drive overload protection acts.
// [RULE8] Code 6 active at zero output frequency while running, off when stopped.
// [RULE9] Code 7 active at zero output frequency, stays active when stopped.
// [RULE10] Code 8 active when running frequency reaches the upper limit.
// [RULE11] Code 9 active at lower limit, inactive when stopped.
// [RULE12] Codes 10 and 11 active when counter reaches set or designated count.
// [RULE13] Code 12 active when actual length exceeds the length target.
// [RULE14] Code 13 emits one 250 ms pulse per finished sequencer cycle.
// [RULE15] Code 14 active when accumulated running time exceeds its threshold.
// [RULE16] Code 15 active when set frequency is beyond a limit and output reached it.
// [RULE17] Code 16 active in speed mode at torque limit with stall protection.
// [RULE18] Code 17 active when circuits stable, no fault, and ready to run.
// [RULE19] Code 18 active while running, even at zero frequency.
// [RULE20] Code 19 active when first analog input exceeds second.
// [RULE21] Code 20 active in undervoltage.
// [RULE22] Reserved or undocumented codes, 21 and above, leave the terminal inactive.
//
// Register access over AHB-Lite and the register offsets are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
`include "otf_defines.svh"

module otf_output_select #(
   parameter int unsigned SEQ_PULSE_CYCLES = `OTF_SEQ_PULSE_CYCLES
) (
   input  wire logic             hclk,
   input  wire logic             hresetn,
   input  wire logic             hsel,
   input  wire logic [7:0]       haddr,
   input  wire logic [1:0]       htrans,
   input  wire logic             hwrite,
   input  wire logic [2:0]       hsize,
   input  wire logic [31:0]      hwdata,
   input  wire logic             hready,
   output logic [31:0]           hrdata,
   output logic                  hreadyout,
   output logic                  hresp,
   input  wire logic             fast_pulse_input,
   input  wire logic             freq_reached,
   input  wire logic             freq_level_detect_one,
   input  wire logic             drive_running,
   input  wire logic             fault_stop,
   input  wire logic             motor_overload_warn,
   input  wire logic             drive_overload_building,
   input  wire otf_pkg::otf_val_t drive_overload_ms_left,
   input  wire otf_pkg::otf_val_t out_freq,
   input  wire otf_pkg::otf_val_t set_freq,
   input  wire otf_pkg::otf_val_t freq_upper_limit,
   input  wire otf_pkg::otf_val_t freq_lower_limit,
   input  wire otf_pkg::otf_val_t count_value,
   input  wire otf_pkg::otf_val_t set_count_value,
   input  wire otf_pkg::otf_val_t designated_count_value,
   input  wire otf_pkg::otf_val_t actual_length,
   input  wire otf_pkg::otf_val_t length_target,
   input  wire logic             step_sequencer_cycle_done,
   input  wire otf_pkg::otf_val_t run_time_total,
   input  wire otf_pkg::otf_val_t run_time_threshold,
   input  wire logic             speed_control_mode,
   input  wire logic             torque_at_limit,
   input  wire logic             stall_protection,
   input  wire logic             circuits_stable,
   input  wire logic             fault_detected,
   input  wire otf_pkg::otf_val_t first_analog_input,
   input  wire otf_pkg::otf_val_t second_analog_input,
   input  wire logic             undervoltage,
   output logic                  fast_output_terminal,
   output logic                  first_relay,
   output logic                  second_relay,
   output logic                  open_collector_output
);
   import otf_pkg::*;

   logic       fast_terminal_mode;
   otf_sel_t   fast_switch_function_select;
   otf_sel_t   first_relay_function_select;
   otf_sel_t   second_relay_function_select;
   otf_sel_t   open_collector_function_select;
   logic       ph_write;
   logic [7:0] ph_addr;
   logic       addr_phase;
   logic       wr_sel;
   logic       seq_pulse;
   logic [31:0] seq_cnt;
   logic       fast_switch_level;
   logic [31:0] next_rdata;
   otf_cond_t  cond;

   // Code zero and codes past the table fall out as inactive
   function automatic logic pick(input otf_sel_t code, input otf_cond_t c);
      if (code > `OTF_CODE_LAST)
         pick = 1'b0; // RULE22
      else
         pick = c[code[4:0]];
   endfunction

   function automatic logic [31:0] reg_read(input logic [7:0] a, input otf_sel_t s0,
                                            input otf_sel_t s1, input otf_sel_t s2,
                                            input otf_sel_t s3, input logic m);
      case (a)
         `OTF_ADDR_FAST_MODE:  reg_read = {31'h0000_0000, m};
         `OTF_ADDR_FAST_SEL:   reg_read = {24'h00_0000, s0};
         `OTF_ADDR_RELAY1_SEL: reg_read = {24'h00_0000, s1};
         `OTF_ADDR_RELAY2_SEL: reg_read = {24'h00_0000, s2};
         `OTF_ADDR_OC_SEL:     reg_read = {24'h00_0000, s3};
         `OTF_ADDR_STATUS:     reg_read = {27'h000_0000, seq_pulse, open_collector_output,
                                           second_relay, first_relay, fast_switch_level};
         default:              reg_read = 32'h0000_0000;
      endcase
   endfunction

   assign addr_phase = hsel && hready && htrans[1];
   assign wr_sel = ph_write && (hwdata[31:8] == 24'h00_0000)
                   && (hwdata[7:0] <= `OTF_SEL_MAX); // RULE2

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ph_write <= 1'b0;
         ph_addr  <= 8'h00;
      end else if (hready) begin
         ph_write <= addr_phase && hwrite;
         ph_addr  <= {haddr[7:2], 2'b00};
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         fast_terminal_mode             <= `OTF_RST_FAST_MODE;
         fast_switch_function_select    <= `OTF_RST_FAST_SEL; // RULE3
         first_relay_function_select    <= `OTF_RST_RELAY1_SEL; // RULE3
         second_relay_function_select   <= `OTF_RST_RELAY2_SEL; // RULE3
         open_collector_function_select <= `OTF_RST_OC_SEL; // RULE3
      end else if (ph_write) begin
         case (ph_addr)
            `OTF_ADDR_FAST_MODE:
               fast_terminal_mode <= hwdata[`OTF_MODE_SWITCH_BIT];
            `OTF_ADDR_FAST_SEL:
               if (wr_sel) fast_switch_function_select <= hwdata[7:0];
            `OTF_ADDR_RELAY1_SEL:
               if (wr_sel) first_relay_function_select <= hwdata[7:0];
            `OTF_ADDR_RELAY2_SEL:
               if (wr_sel) second_relay_function_select <= hwdata[7:0];
            `OTF_ADDR_OC_SEL:
               if (wr_sel) open_collector_function_select <= hwdata[7:0];
            default: ;
         endcase
      end
   end

   // Forward a write still in its data phase so back-to-back reads see it
   always_comb begin
      next_rdata = reg_read({haddr[7:2], 2'b00}, fast_switch_function_select,
                            first_relay_function_select, second_relay_function_select,
                            open_collector_function_select, fast_terminal_mode);
      if (ph_write && (ph_addr == {haddr[7:2], 2'b00})) begin
         if (ph_addr == `OTF_ADDR_FAST_MODE)
            next_rdata = {31'h0000_0000, hwdata[`OTF_MODE_SWITCH_BIT]};
         else if (ph_addr != `OTF_ADDR_STATUS && wr_sel)
            next_rdata = {24'h00_0000, hwdata[7:0]};
      end
   end

   // Zero wait states and always OKAY keep the master simple
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hrdata    <= 32'h0000_0000;
         hreadyout <= 1'b0;
         hresp     <= 1'b0;
      end else begin
         hreadyout <= 1'b1;
         hresp     <= 1'b0;
         if (addr_phase && !hwrite)
            hrdata <= next_rdata;
      end
   end

   // Sequencer pulse; a new cycle end while high restarts the width
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         seq_pulse <= 1'b0;
         seq_cnt   <= 32'h0000_0000;
      end else if (step_sequencer_cycle_done) begin
         seq_pulse <= 1'b1; // RULE14
         seq_cnt   <= SEQ_PULSE_CYCLES - 1;
      end else if (seq_cnt != 32'h0000_0000) begin
         seq_cnt <= seq_cnt - 32'h0000_0001;
      end else begin
         seq_pulse <= 1'b0; // RULE14
      end
   end

   always_comb begin
      cond = '0;
      cond[OTF_C_FREQ_REACHED]   = freq_reached;
      cond[OTF_C_FREQ_LEVEL_ONE] = freq_level_detect_one;
      cond[OTF_C_FAULT_STOP]     = fault_stop; // RULE5
      cond[OTF_C_MOTOR_OVL_WARN] = motor_overload_warn; // RULE6
      cond[OTF_C_DRIVE_OVL_WARN] = drive_overload_building
                                   && (drive_overload_ms_left <= `OTF_DRV_PREWARN_MS); // RULE7
      cond[OTF_C_ZERO_RUN]       = drive_running && (out_freq == 16'h0000); // RULE8
      cond[OTF_C_ZERO_ANY]       = (out_freq == 16'h0000); // RULE9
      cond[OTF_C_UPPER_LIMIT]    = drive_running && (out_freq >= freq_upper_limit); // RULE10
      cond[OTF_C_LOWER_LIMIT]    = drive_running && (out_freq <= freq_lower_limit); // RULE11
      cond[OTF_C_SET_COUNT]      = (count_value >= set_count_value); // RULE12
      cond[OTF_C_DESIG_COUNT]    = (count_value >= designated_count_value); // RULE12
      cond[OTF_C_LENGTH]         = (actual_length > length_target); // RULE13
      cond[OTF_C_SEQ_CYCLE]      = seq_pulse; // RULE14
      cond[OTF_C_RUN_TIME]       = (run_time_total > run_time_threshold); // RULE15
      cond[OTF_C_FREQ_LIMITED]   = ((set_freq > freq_upper_limit)
                                    && (out_freq >= freq_upper_limit))
                                   || ((set_freq < freq_lower_limit)
                                    && (out_freq <= freq_lower_limit)); // RULE16
      cond[OTF_C_TORQUE_LIMITED] = speed_control_mode && torque_at_limit
                                   && stall_protection; // RULE17
      cond[OTF_C_READY]          = circuits_stable && !fault_detected; // RULE18
      cond[OTF_C_RUNNING]        = drive_running; // RULE19
      cond[OTF_C_ANALOG_CMP]     = ($signed(first_analog_input)
                                    > $signed(second_analog_input)); // RULE20
      cond[OTF_C_UNDERVOLTAGE]   = undervoltage; // RULE21
      cond[OTF_C_NONE]           = 1'b0; // RULE4
   end

   assign fast_switch_level = pick(fast_switch_function_select, cond);

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         fast_output_terminal  <= 1'b0;
         first_relay           <= 1'b0;
         second_relay          <= 1'b0;
         open_collector_output <= 1'b0;
      end else begin
         fast_output_terminal  <= fast_terminal_mode ? fast_switch_level
                                                     : fast_pulse_input; // RULE1
         first_relay           <= pick(first_relay_function_select, cond); // RULE2
         second_relay          <= pick(second_relay_function_select, cond); // RULE2
         open_collector_output <= pick(open_collector_function_select, cond); // RULE2
      end
   end

   default clocking otf_cb @(posedge hclk);
   endclocking
   default disable iff (!hresetn);

   sequence s_sel_write_addr;
      addr_phase && hwrite && ({haddr[7:2], 2'b00} == `OTF_ADDR_RELAY2_SEL);
   endsequence

   sequence s_sel_bad_data;
      hwdata[7:0] > `OTF_SEL_MAX;
   endsequence

   AST_PULSE_MODE: assert property (!fast_terminal_mode |=> // RULE1
      fast_output_terminal == $past(fast_pulse_input))
      else $error("fast terminal does not follow pulse input in mode 0");

   AST_BAD_CODE_KEEPS: assert property (s_sel_write_addr ##1 s_sel_bad_data |=> // RULE2
      $stable(second_relay_function_select))
      else $error("out-of-range selection code was stored");

   AST_RESET_VALUES: assert property ($rose(hresetn) |-> // RULE3
      first_relay_function_select == 8'h02 && second_relay_function_select == 8'h00
      && fast_switch_function_select == 8'h00 && open_collector_function_select == 8'h01)
      else $error("selection reset values wrong");

   AST_CODE_ZERO: assert property (second_relay_function_select == 8'h00 |=> // RULE4
      !second_relay)
      else $error("code 0 drove relay active");

   AST_FAULT_CODE: assert property ((second_relay_function_select == 8'h03) && fault_stop
      |=> second_relay) // RULE5
      else $error("fault stop did not drive terminal");

   AST_DRV_PREWARN: assert property ((second_relay_function_select == 8'h05) // RULE7
      && drive_overload_building && (drive_overload_ms_left == 16'h2710)
      |=> second_relay)
      else $error("drive overload pre-warning missed at 10 s");

   AST_ZERO_STOPPED: assert property ((second_relay_function_select == 8'h06) // RULE8
      && !drive_running |=> !second_relay)
      else $error("code 6 active while stopped");

   AST_SEQ_WIDTH: assert property ($rose(seq_pulse) |-> seq_pulse[*8]) // RULE14
      else $error("sequencer pulse too short");

   AST_SEQ_ENDS: assert property (seq_pulse && seq_cnt == 32'h0 // RULE14
      && !step_sequencer_cycle_done |=> !seq_pulse)
      else $error("sequencer pulse did not end");

   AST_RESERVED: assert property ((second_relay_function_select inside {[8'h15:8'h28]}) // RULE22
      |=> !second_relay)
      else $error("reserved code drove relay");

   AST_UNDERV: assert property ((second_relay_function_select == 8'h14) && undervoltage // RULE21
      |=> second_relay)
      else $error("undervoltage not shown");

   AST_MOTOR_WARN: assert property ((second_relay_function_select == 8'h04) // RULE6
      && motor_overload_warn |=> second_relay)
      else $error("motor overload pre-warning not shown");

   AST_ZERO_ANY: assert property ((second_relay_function_select == 8'h07) // RULE9
      && (out_freq == 16'h0000) |=> second_relay)
      else $error("zero frequency not shown");

   AST_UPPER: assert property ((second_relay_function_select == 8'h08) // RULE10
      && drive_running && (out_freq >= freq_upper_limit) |=> second_relay)
      else $error("upper limit not shown");

   AST_LOWER_STOP: assert property ((second_relay_function_select == 8'h09) // RULE11
      && !drive_running |=> !second_relay)
      else $error("lower limit active while stopped");

   AST_SET_COUNT: assert property ((second_relay_function_select == 8'h0A) // RULE12
      && (count_value >= set_count_value) |=> second_relay)
      else $error("set count not shown");

   AST_LENGTH: assert property ((second_relay_function_select == 8'h0C) // RULE13
      && (actual_length > length_target) |=> second_relay)
      else $error("length target not shown");

   AST_RUN_TIME: assert property ((second_relay_function_select == 8'h0E) // RULE15
      && (run_time_total > run_time_threshold) |=> second_relay)
      else $error("running time not shown");

   AST_FREQ_LIMITED: assert property ((second_relay_function_select == 8'h0F) // RULE16
      && (set_freq > freq_upper_limit) && (out_freq >= freq_upper_limit) |=> second_relay)
      else $error("frequency limited not shown");

   AST_TORQUE: assert property ((second_relay_function_select == 8'h10) // RULE17
      && speed_control_mode && torque_at_limit && stall_protection |=> second_relay)
      else $error("torque limited not shown");

   AST_READY: assert property ((second_relay_function_select == 8'h11) // RULE18
      && circuits_stable && !fault_detected |=> second_relay)
      else $error("ready not shown");

   AST_RUNNING: assert property ((second_relay_function_select == 8'h12) // RULE19
      && drive_running |=> second_relay)
      else $error("running not shown");

   AST_ANALOG: assert property ((second_relay_function_select == 8'h13) // RULE20
      && ($signed(first_analog_input) > $signed(second_analog_input)) |=> second_relay)
      else $error("analog comparison not shown");

endmodule
`default_nettype wire

// >>> testbench/otf_load_model.sv
`timescale 1ns/1ps
`default_nettype none
module otf_load_model (
   input  wire logic        hclk,
   input  wire logic        hresetn,
   input  wire logic        oc_drive,
   output logic [15:0]      oc_on_cycles
);
   // Open-collector load: tallies cycles the transistor conducts
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         oc_on_cycles <= 16'h0000;
      end else if (oc_drive) begin
         oc_on_cycles <= oc_on_cycles + 16'h0001;
      end
   end
endmodule
`default_nettype wire

// >>> testbench/otf_output_select_tb.sv
`timescale 1ns/1ps
`default_nettype none
module otf_output_select_tb;
   import otf_pkg::*;
   localparam int unsigned PULSE = 20;
   logic        hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp;
   logic [7:0]  haddr;
   logic [1:0]  htrans;
   logic [2:0]  hsize;
   logic [31:0] hwdata, hrdata;
   logic        fast_pulse_input, freq_reached, freq_level_detect_one, drive_running;
   logic        fault_stop, motor_overload_warn, drive_overload_building, undervoltage;
   logic        step_sequencer_cycle_done, speed_control_mode, torque_at_limit;
   logic        stall_protection, circuits_stable, fault_detected;
   otf_val_t    drive_overload_ms_left, out_freq, set_freq, freq_upper_limit;
   otf_val_t    freq_lower_limit, count_value, set_count_value, designated_count_value;
   otf_val_t    actual_length, length_target, run_time_total, run_time_threshold;
   otf_val_t    first_analog_input, second_analog_input;
   logic        fast_output_terminal, first_relay, second_relay, open_collector_output;
   logic [15:0] oc_on_cycles;
   int          error_cnt, n_checks;

   assign hready = hreadyout;

   otf_output_select #(.SEQ_PULSE_CYCLES(PULSE)) u_dut (
      .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready,
      .hrdata, .hreadyout, .hresp, .fast_pulse_input, .freq_reached,
      .freq_level_detect_one, .drive_running, .fault_stop, .motor_overload_warn,
      .drive_overload_building, .drive_overload_ms_left, .out_freq, .set_freq,
      .freq_upper_limit, .freq_lower_limit, .count_value, .set_count_value,
      .designated_count_value, .actual_length, .length_target,
      .step_sequencer_cycle_done, .run_time_total, .run_time_threshold,
      .speed_control_mode, .torque_at_limit, .stall_protection, .circuits_stable,
      .fault_detected, .first_analog_input, .second_analog_input, .undervoltage,
      .fast_output_terminal, .first_relay, .second_relay, .open_collector_output
   );

   otf_load_model u_load (.hclk, .hresetn, .oc_drive(open_collector_output), .oc_on_cycles);

   always #2 hclk = ~hclk;

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         error_cnt++;
         $display("Error t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic test_done();
      $display("checks=%0d errors=%0d", n_checks, error_cnt);
      if (error_cnt == 0 && n_checks > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask

   // Entered right after a rising edge; hangs are left to the watchdog
   task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q);
      hsel <= 1'b1;
      haddr <= a;
      htrans <= 2'h2;
      hwrite <= wr;
      hsize <= 3'h2;
      do @(posedge hclk); while (hready !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge hclk); while (hready !== 1'b1);
      q = hrdata;
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      bus(1'b1, a, d, q);
   endtask

   task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
      logic [31:0] q;
      bus(1'b0, a, 32'h0, q);
      check(q, e);
      check(hresp, 1'b0);
   endtask

   // One registered stage, visible after the first edge; the second edge is margin
   task automatic settle();
      repeat (2) @(posedge hclk);
   endtask

   // Code 0 is the quiet baseline; equal length, run time and analog values sit on the off side of their thresholds
   task automatic set_cond(input int c);
      freq_reached <= (c == 1);
      freq_level_detect_one <= (c == 2);
      fault_stop <= (c == 3);
      fault_detected <= (c == 3);
      motor_overload_warn <= (c == 4);
      drive_overload_building <= (c == 5);
      drive_overload_ms_left <= (c == 5) ? 16'h2710 : 16'hFFFF;
      drive_running <= (c inside {6, 8, 9, 18});
      out_freq <= (c inside {6, 7, 18}) ? 16'h0000 : (c inside {8, 15}) ? 16'h0500 :
                  (c == 9) ? 16'h0100 : 16'h0200;
      set_freq <= (c == 15) ? 16'h0600 : 16'h0200;
      freq_upper_limit <= 16'h0500;
      freq_lower_limit <= 16'h0100;
      count_value <= (c == 10) ? 16'h0100 : (c == 11) ? 16'h0200 : 16'h0000;
      set_count_value <= 16'h0100;
      designated_count_value <= 16'h0200;
      actual_length <= (c == 12) ? 16'h0101 : 16'h0100;
      length_target <= 16'h0100;
      step_sequencer_cycle_done <= 1'b0;
      run_time_total <= (c == 14) ? 16'h0101 : 16'h0100;
      run_time_threshold <= 16'h0100;
      speed_control_mode <= (c == 16);
      torque_at_limit <= (c == 16);
      stall_protection <= (c == 16);
      circuits_stable <= (c == 17);
      first_analog_input <= (c == 19) ? 16'h0005 : 16'h0000;
      second_analog_input <= (c == 19) ? 16'hFFFB : 16'h0000;
      undervoltage <= (c == 20);
   endtask

   task automatic t_reset();
      rd_chk(8'h00, 32'h0);
      rd_chk(8'h04, 32'h0);
      rd_chk(8'h08, 32'h2);
      rd_chk(8'h0C, 32'h0);
      rd_chk(8'h10, 32'h1);
      rd_chk(8'h20, 32'h0);
      set_cond(2);
      settle();
      check({first_relay, open_collector_output}, 2'b10);
      set_cond(1);
      settle();
      check({first_relay, open_collector_output}, 2'b01);
   endtask

   task automatic t_codes();
      for (int c = 1; c <= 20; c++) begin
         if (c != 13) begin
            set_cond(0);
            wr(8'h0C, c);
            settle();
            check(second_relay, 1'b0);
            set_cond(c);
            settle();
            check(second_relay, 1'b1);
            if (c inside {6, 9, 18}) begin
               drive_running <= 1'b0;
               settle();
               check(second_relay, 1'b0);
            end
         end
      end
   endtask

   task automatic t_reserved();
      int codes[6] = '{0, 21, 22, 23, 24, 40};
      foreach (codes[k]) begin
         wr(8'h0C, codes[k]);
         for (int j = 1; j <= 20; j++) begin
            set_cond(j);
            settle();
            check(second_relay, 1'b0);
         end
      end
      wr(8'h0C, 32'd41);
      rd_chk(8'h0C, 32'd40);
      wr(8'h04, 32'd40);
      rd_chk(8'h04, 32'd40);
   endtask

   task automatic t_fast();
      for (int i = 0; i < 4; i++) begin
         fast_pulse_input <= i[0];
         settle();
         check(fast_output_terminal, i[0]);
      end
      wr(8'h00, 32'h1);
      wr(8'h04, 32'd3);
      set_cond(3);
      settle();
      check(fast_output_terminal, 1'b1);
      rd_chk(8'h14, 32'h1);
      set_cond(0);
      fast_pulse_input <= 1'b1;
      settle();
      check(fast_output_terminal, 1'b0);
   endtask

   task automatic t_seq();
      logic [15:0] base;
      wr(8'h10, 32'd13);
      set_cond(0);
      settle();
      base = oc_on_cycles;
      step_sequencer_cycle_done <= 1'b1;
      @(posedge hclk);
      step_sequencer_cycle_done <= 1'b0;
      repeat (PULSE + 5) @(posedge hclk);
      check(oc_on_cycles - base, PULSE);
   endtask

   initial begin
      #40000;
      error_cnt++;
      test_done();
   end

   initial begin
      hclk = 1'b0;
      hresetn = 1'b0;
      hsel = 1'b0;
      haddr = 8'h00;
      htrans = 2'h0;
      hwrite = 1'b0;
      hsize = 3'h2;
      hwdata = 32'h0;
      fast_pulse_input = 1'b0;
      error_cnt = 0;
      n_checks = 0;
      set_cond(0);
      repeat (4) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      t_reset();
      t_codes();
      t_reserved();
      t_fast();
      t_seq();
      test_done();
   end
endmodule
`default_nettype wire
